// >>> include/clk_ctrl_defs.vh
// Register map, field positions, reset values and timing counts
// for the system and timer clock control block.
`ifndef CLK_CTRL_DEFS_VH
`define CLK_CTRL_DEFS_VH

// Printed offsets are register indices; byte address is four times
`define SYS_CLK_CTRL_IDX   32'h5000000A
`define TMR_CLK_CTRL_IDX   32'h5000000C

// System clock control fields
`define SYS_PLL_FLAG_BIT   15
`define SYS_XTAL_FLAG_BIT  14
`define SYS_RC_FLAG_BIT    13
`define SYS_SLOW_FLAG_BIT  12
`define LP_SRC_MSB         9
`define LP_SRC_LSB         8
`define DIVIDED_SYSTEM_CLOCK_HALVE_BIT     6
`define PLL_HALVE_BIT      5
`define USB_SRC_BIT        4
`define FAST_XTAL_DIV_BIT  3
`define XTAL_OFF_BIT       2
`define SYS_SEL_MSB        1
`define SYS_SEL_LSB        0

// System clock source codes
`define SRC_XTAL           2'h0
`define SRC_RC             2'h1
`define SRC_LOW_POWER      2'h2
`define SRC_PLL            2'h3

// Timer clock control fields
`define PWM_PAD_MAP_BIT    14
`define WAKE_CLK_EN_BIT    13
`define BREATH_CLK_EN_BIT  12
`define TMR2_LSB           8
`define TMR1_LSB           4
`define TMR0_LSB           0

// Reset values
`define SYS_CTRL_RESET     16'h0001
`define TMR_CTRL_RESET     16'h0000

// Source switch settle time and core clock period
`define SWITCH_TIME_NS     200
`define CORE_CLK_PERIOD_NS 50

`endif

// >>> design/clk_source_switch.v
// Tracks which system clock source is really driving the system.
// Assumes sourceReady comes from the oscillators, synchronous to core_clk.
`timescale 1ns/1ns
`include "clk_ctrl_defs.vh"

module clk_source_switch (
    input  wire       core_clk,
    input  wire       rstn,
    input  wire [1:0] requestSelect,
    input  wire [3:0] sourceReady,
    output reg  [1:0] activeSelect_ff,
    output wire       switchBusy
);
    // Least settle time rounds up to whole cycles
    localparam SETTLE_CYCLES = (`SWITCH_TIME_NS + `CORE_CLK_PERIOD_NS - 1)
                               / `CORE_CLK_PERIOD_NS;
    localparam [31:0] SETTLE_SPAN = SETTLE_CYCLES - 1;
    localparam [3:0]  SETTLE_LAST = SETTLE_SPAN[3:0];
    localparam ST_IDLE   = 1'b0;
    localparam ST_SETTLE = 1'b1;

    reg       state_ff;
    reg [1:0] target_ff;
    reg [3:0] count_ff;

    assign switchBusy = (requestSelect != activeSelect_ff);

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff        <= ST_IDLE;
            target_ff       <= `SRC_RC;
            count_ff        <= 4'h0;
            activeSelect_ff <= `SRC_RC;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    // Move only to a source that reports ready
                    if (switchBusy && sourceReady[requestSelect]) begin
                        target_ff <= requestSelect;
                        count_ff  <= 4'h0;
                        state_ff  <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (requestSelect != target_ff ||
                            !sourceReady[target_ff]) begin
                        state_ff <= ST_IDLE;
                    end else if (count_ff == SETTLE_LAST) begin
                        activeSelect_ff <= target_ff;
                        state_ff        <= ST_IDLE;
                    end else begin
                        count_ff <= count_ff + 4'h1;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule // clk_source_switch

// >>> design/timer_clock_gen.v
// One timer clock: gate, source select and divide by 1, 2, 4 or 8.
// Assumes dividedTick is a one-cycle enable pulse on core_clk.
`timescale 1ns/1ns

module timer_clock_gen (
    input  wire       core_clk,
    input  wire       rstn,
    input  wire       clockGate,
    input  wire       sourceSelect,
    input  wire [1:0] divider,
    input  wire       dividedTick,
    output reg        timerTick_ff
);
    reg  [2:0] count_ff;
    wire       sourceTick;
    wire [2:0] countLast;

    // 1 picks the undivided clock, 0 the divided one
    assign sourceTick = sourceSelect ? 1'b1 : dividedTick;
    assign countLast  = (3'h1 << divider) - 3'h1;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count_ff     <= 3'h0;
            timerTick_ff <= 1'b0;
        end else if (!clockGate) begin
            count_ff     <= 3'h0;
            timerTick_ff <= 1'b0;
        end else if (sourceTick) begin
            if (count_ff >= countLast) begin
                count_ff     <= 3'h0;
                timerTick_ff <= 1'b1;
            end else begin
                count_ff     <= count_ff + 3'h1;
                timerTick_ff <= 1'b0;
            end
        end else begin
            timerTick_ff <= 1'b0;
        end
    end
endmodule // timer_clock_gen

// >>> design/clock_control.v
// System and timer clock control with an APB register slave.
// Assumes all inputs synchronous to core_clk; core_clk is the AHB clock.
//
// Functional notes
// - Bit 15 reads one while the PLL drives the system.
// - Bit 14 reads one while the fast crystal drives the system.
// - Bit 13 reads one while the fast RC drives; one after reset.
// - Bit 12 reads one while either slow clock drives the system.
// - Bits 9:8 choose the low-power clock source, four options.
// - Bit 6 halves the divided system clock for a doubled crystal.
// - Bit 5 halves the PLL clock before any downstream use.
// - Bit 4 picks USB clock: 0 halved PLL, 1 AHB clock.
// - Bit 3 enables crystal dividers feeding both radio PLLs.
// - Bit 2 stops the fast crystal at once, no handshake.
// - Bits 1:0 select crystal, RC, low-power or PLL system source.
// - Timer bit 14 maps timer-1 PWM to pad if debug off; kept asleep.
// - Each timer has its own gate and undivided/divided source select.
// - Each timer divides its source by 1, 2, 4 or 8.
`timescale 1ns/1ns
`include "clk_ctrl_defs.vh"

module clock_control #(
    parameter ADDR_W = 8
) (
    input  wire              core_clk,
    input  wire              rstn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    input  wire [3:0]        sourceReady,
    input  wire              crystalSettledFlag,
    input  wire              debugPortEnable,
    input  wire              deepSleep,
    output wire [1:0]        activeSourceSelect,
    output wire [1:0]        lowPowerClockSource,
    output wire              dividedClockHalveEnable,
    output wire              pllHalveEnable,
    output wire              usbClockSourceSelect,
    output wire              fastCrystalDividerEnable,
    output wire              crystalOscillatorOff,
    output reg               dividedClockTick_ff,
    output reg               pllClockTick_ff,
    output reg               usbClockTick_ff,
    output wire [2:0]        timerTick,
    output reg               wakeCounterTick_ff,
    output reg               breathingLedTick_ff,
    output reg               timer1PwmPadMap_ff
);
    localparam [31:0] SYS_IDX = `SYS_CLK_CTRL_IDX;
    localparam [31:0] TMR_IDX = `TMR_CLK_CTRL_IDX;
    localparam [ADDR_W-1:0] SYS_ADDR = {SYS_IDX[ADDR_W-3:0], 2'b00};
    localparam [ADDR_W-1:0] TMR_ADDR = {TMR_IDX[ADDR_W-3:0], 2'b00};

    reg  [15:0] sysCtrl_ff;
    reg  [15:0] tmrCtrl_ff;
    reg         divnPhase_ff;
    reg         pllPhase_ff;
    reg         usbPhase_ff;
    reg  [15:0] nxt_rdata;
    wire [1:0]  activeSel;
    wire [3:0]  readyGated;
    wire [15:0] sysView;
    wire        hitSys;
    wire        hitTmr;
    wire        mapped;
    wire        wrStrobe;

    // Bus decode; zero wait states
    assign hitSys   = (paddr == SYS_ADDR);
    assign hitTmr   = (paddr == TMR_ADDR);
    assign mapped   = hitSys | hitTmr;
    assign pready   = psel & penable;
    assign pslverr  = psel & penable & ~mapped;
    assign wrStrobe = psel & penable & pwrite & mapped;

    // Control bits straight from the register; active select from the switch
    assign lowPowerClockSource =
        sysCtrl_ff[`LP_SRC_MSB:`LP_SRC_LSB];
    assign dividedClockHalveEnable = sysCtrl_ff[`DIVIDED_SYSTEM_CLOCK_HALVE_BIT];
    assign pllHalveEnable = sysCtrl_ff[`PLL_HALVE_BIT];
    assign usbClockSourceSelect = sysCtrl_ff[`USB_SRC_BIT];
    assign fastCrystalDividerEnable =
        sysCtrl_ff[`FAST_XTAL_DIV_BIT];
    assign crystalOscillatorOff = sysCtrl_ff[`XTAL_OFF_BIT];
    assign activeSourceSelect = activeSel;

    // A stopped or unsettled crystal is never a switch target
    assign readyGated = {sourceReady[3:1],
                         sourceReady[0] & crystalSettledFlag &
                         ~crystalOscillatorOff};

    clk_source_switch u_switch (
        .core_clk        (core_clk),
        .rstn            (rstn),
        .requestSelect   (sysCtrl_ff[`SYS_SEL_MSB:`SYS_SEL_LSB]),
        .sourceReady     (readyGated),
        .activeSelect_ff (activeSel),
        .switchBusy      ()
    );

    // Status flags decoded from the confirmed source only
    assign sysView = {activeSel == `SRC_PLL,
                      activeSel == `SRC_XTAL,
                      activeSel == `SRC_RC,
                      activeSel == `SRC_LOW_POWER,
                      2'b00,
                      sysCtrl_ff[9:8],
                      1'b0,
                      sysCtrl_ff[6:0]};

    // Register writes; status bits and reserved bits are not stored
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sysCtrl_ff <= `SYS_CTRL_RESET;
            tmrCtrl_ff <= `TMR_CTRL_RESET;
        end else if (wrStrobe) begin
            if (hitSys) begin
                sysCtrl_ff <= {6'h00, pwdata[9:8], 1'b0, pwdata[6:0]};
            end
            if (hitTmr) begin
                tmrCtrl_ff <= {1'b0, pwdata[14:0]};
            end
        end
    end

    // Read data is captured in the setup cycle
    always @* begin
        nxt_rdata = 16'h0000;
        if (hitSys) begin
            nxt_rdata = sysView;
        end else if (hitTmr) begin
            nxt_rdata = tmrCtrl_ff;
        end
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {16'h0000, nxt_rdata};
        end
    end

    // Divided, PLL and USB clock enables
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            divnPhase_ff        <= 1'b0;
            pllPhase_ff         <= 1'b0;
            usbPhase_ff         <= 1'b0;
            dividedClockTick_ff <= 1'b0;
            pllClockTick_ff     <= 1'b0;
            usbClockTick_ff     <= 1'b0;
        end else begin
            divnPhase_ff <= ~divnPhase_ff;
            pllPhase_ff  <= ~pllPhase_ff;
            dividedClockTick_ff <=
                ~dividedClockHalveEnable | divnPhase_ff;
            pllClockTick_ff <= ~pllHalveEnable | pllPhase_ff;
            if (pllClockTick_ff) begin
                usbPhase_ff <= ~usbPhase_ff;
            end
            if (usbClockSourceSelect) begin
                usbClockTick_ff <= 1'b1;
            end else begin
                usbClockTick_ff <= pllClockTick_ff & usbPhase_ff;
            end
        end
    end

    // Three timer clocks, one generator each
    genvar t;
    generate
        for (t = 0; t < 3; t = t + 1) begin : g_timer
            timer_clock_gen u_timer (
                .core_clk     (core_clk),
                .rstn         (rstn),
                .clockGate    (tmrCtrl_ff[4*t+2]),
                .sourceSelect (tmrCtrl_ff[4*t+3]),
                .divider      (tmrCtrl_ff[4*t+1:4*t]),
                .dividedTick  (dividedClockTick_ff),
                .timerTick_ff (timerTick[t])
            );
        end
    endgenerate

    // Wake counter, breathing clock gates and PWM pad mapping
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wakeCounterTick_ff  <= 1'b0;
            breathingLedTick_ff <= 1'b0;
            timer1PwmPadMap_ff  <= 1'b0;
        end else begin
            wakeCounterTick_ff  <= tmrCtrl_ff[`WAKE_CLK_EN_BIT] &
                                   dividedClockTick_ff;
            breathingLedTick_ff <= tmrCtrl_ff[`BREATH_CLK_EN_BIT] &
                                   dividedClockTick_ff;
            // Mapping frozen while in deep sleep
            if (!deepSleep) begin
                timer1PwmPadMap_ff <= tmrCtrl_ff[`PWM_PAD_MAP_BIT] &
                                      ~debugPortEnable;
            end
        end
    end
endmodule // clock_control

// >>> tb/clock_control_props.sv
// Port-level assertions for clock_control.
// Assumes byte addresses 0x28 (system) and 0x30 (timer), zero-wait APB.
`timescale 1ns/1ns
module clock_control_props #(
    parameter ADDR_W = 8
) (
    input wire              core_clk,
    input wire              rstn,
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0]       pwdata,
    input wire [31:0]       prdata,
    input wire [3:0]        sourceReady,
    input wire              debugPortEnable,
    input wire              deepSleep,
    input wire [1:0]        activeSourceSelect,
    input wire [1:0]        lowPowerClockSource,
    input wire              dividedClockHalveEnable,
    input wire              pllHalveEnable,
    input wire              usbClockSourceSelect,
    input wire              crystalOscillatorOff,
    input wire              dividedClockTick_ff,
    input wire              pllClockTick_ff,
    input wire              usbClockTick_ff,
    input wire              timer1PwmPadMap_ff
);
    wire       wrSys = psel && penable && pwrite && paddr == 8'h28;
    wire       rdSet = psel && !penable && !pwrite && paddr == 8'h28;
    wire [1:0] act = activeSourceSelect;
    wire [3:0] flagExp = {act == 2'h3, act == 2'h0, act == 2'h1, act == 2'h2};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_flags; rdSet |=> prdata[15:12] == $past(flagExp); endproperty
    a_flags: assert property (p_flags)
        else $error("status flags do not match active source");
    property p_lpSrc; wrSys |=> lowPowerClockSource == $past(pwdata[9:8]);
    endproperty
    a_lpSrc: assert property (p_lpSrc)
        else $error("low-power source field not taken");
    property p_divFull; $past(rstn) && !dividedClockHalveEnable &&
        $past(!dividedClockHalveEnable) |-> dividedClockTick_ff; endproperty
    a_divFull: assert property (p_divFull)
        else $error("divided tick missing while not halved");
    property p_pllHalf; pllHalveEnable [*3] |->
        !(pllClockTick_ff && $past(pllClockTick_ff)); endproperty
    a_pllHalf: assert property (p_pllHalf)
        else $error("pll tick not halved");
    property p_usbSel; usbClockSourceSelect [*2] |-> usbClockTick_ff;
    endproperty
    a_usbSel: assert property (p_usbSel)
        else $error("usb tick not on bus clock");
    property p_xtalOff; wrSys |=> crystalOscillatorOff == $past(pwdata[2]);
    endproperty
    a_xtalOff: assert property (p_xtalOff)
        else $error("crystal stop not immediate");
    property p_selPll; wrSys && pwdata[1:0] == 2'h3 && sourceReady[3] |->
        ##6 activeSourceSelect == 2'h3; endproperty
    a_selPll: assert property (p_selPll)
        else $error("pll switch not completed in time");
    property p_padDebug; debugPortEnable && !deepSleep |=>
        !timer1PwmPadMap_ff; endproperty
    a_padDebug: assert property (p_padDebug)
        else $error("pad mapped while debugger on");
    property p_padHold; deepSleep |=> $stable(timer1PwmPadMap_ff); endproperty
    a_padHold: assert property (p_padHold)
        else $error("pad mapping changed in deep sleep");
    property p_switchHold; $changed(activeSourceSelect) |=>
        $stable(activeSourceSelect) [*4]; endproperty
    a_switchHold: assert property (p_switchHold)
        else $error("source changed before settle time");
endmodule // clock_control_props

bind clock_control clock_control_props #(.ADDR_W(ADDR_W)) props (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .sourceReady(sourceReady), .debugPortEnable(debugPortEnable),
    .deepSleep(deepSleep), .activeSourceSelect(activeSourceSelect),
    .lowPowerClockSource(lowPowerClockSource),
    .dividedClockHalveEnable(dividedClockHalveEnable),
    .pllHalveEnable(pllHalveEnable),
    .usbClockSourceSelect(usbClockSourceSelect),
    .crystalOscillatorOff(crystalOscillatorOff),
    .dividedClockTick_ff(dividedClockTick_ff),
    .pllClockTick_ff(pllClockTick_ff), .usbClockTick_ff(usbClockTick_ff),
    .timer1PwmPadMap_ff(timer1PwmPadMap_ff));

// >>> tb/clock_control_bench.sv
// Self-checking bench for clock_control driven over APB.
// Assumes a zero-wait slave and byte addresses 0x28 and 0x30.
`timescale 1ns/1ns
module clock_control_bench;
    reg         core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0, rd;
    reg  [3:0]  sourceReady = 4'hF;
    reg         crystalSettledFlag = 1, debugPortEnable = 0, deepSleep = 0;
    reg         errSeen;
    wire [31:0] prdata;
    wire        pready, pslverr, dTick, pTick, uTick, wTick, bTick, padMap;
    wire        dHalve, pHalve, usbSel, xDiv, xOff;
    wire [2:0]  timerTick;
    wire [1:0]  actSel, lpSrc;
    wire [7:0]  ticks = {bTick, wTick, timerTick, uTick, pTick, dTick};
    integer     failures = 0, testsRun = 0, cycles = 0, n, i, k;

    clock_control dut (.core_clk(core_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sourceReady(sourceReady), .crystalSettledFlag(crystalSettledFlag),
        .debugPortEnable(debugPortEnable), .deepSleep(deepSleep),
        .activeSourceSelect(actSel), .lowPowerClockSource(lpSrc),
        .dividedClockHalveEnable(dHalve), .pllHalveEnable(pHalve),
        .usbClockSourceSelect(usbSel), .fastCrystalDividerEnable(xDiv),
        .crystalOscillatorOff(xOff), .dividedClockTick_ff(dTick),
        .pllClockTick_ff(pTick), .usbClockTick_ff(uTick),
        .timerTick(timerTick), .wakeCounterTick_ff(wTick),
        .breathingLedTick_ff(bTick), .timer1PwmPadMap_ff(padMap));

    always #25 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            print_verdict;
        end
    end

    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", testsRun, failures);
            if (failures == 0 && testsRun > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    task check(input [31:0] seen, input [31:0] exp);
        begin
            testsRun = testsRun + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("unexpected at %0t: seen %h expected %h",
                         $time, seen, exp);
            end
        end
    endtask

    // Setup cycle, then access held until pready is seen at an edge
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            psel <= 1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge core_clk);
            penable <= 1;
            do @(posedge core_clk); while (pready !== 1'b1);
            rd = prdata;
            errSeen = pslverr;
            psel <= 0;
            penable <= 0;
            // Idle edge: bus released, written outputs settled
            @(posedge core_clk);
        end
    endtask

    task count(input integer idx, input integer exp);
        begin
            n = 0;
            repeat (3) @(posedge core_clk);
            repeat (16) begin
                @(posedge core_clk);
                n = n + ticks[idx];
            end
            check(n, exp);
        end
    endtask

    task pause;
        repeat (8) @(posedge core_clk);
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1;
        @(posedge core_clk);
        apb(0, 8'h28, 0);
        check(rd, 32'h2001);
        apb(0, 8'h2C, 0);
        check({rd[30:0], errSeen}, 32'h1);
        for (i = 0; i < 4; i = i + 1) begin
            k = (i + 3) % 4;
            apb(1, 8'h28, k);
            pause;
            apb(0, 8'h28, 0);
            check(rd, (32'h1 << (k == 3 ? 15 : 14 - k)) | k);
            check(actSel, k);
        end
        sourceReady <= 4'h7;
        apb(1, 8'h28, 3);
        pause;
        apb(0, 8'h28, 0);
        check(rd, 32'h1003);
        sourceReady <= 4'hF;
        pause;
        apb(0, 8'h28, 0);
        check(rd, 32'h8003);
        apb(1, 8'h28, 32'hFFFD);
        pause;
        apb(0, 8'h28, 0);
        check(rd, 32'h237D);
        check({lpSrc, dHalve, pHalve, usbSel, xDiv, xOff}, 7'h7F);
        for (i = 0; i < 4; i = i + 1) begin
            apb(1, 8'h28, (i << 8) | 1);
            check(lpSrc, i);
        end
        count(0, 16);
        count(1, 16);
        count(2, 8);
        apb(1, 8'h28, 32'h71);
        count(0, 8);
        count(1, 8);
        count(2, 16);
        apb(1, 8'h28, 32'h61);
        count(2, 4);
        for (i = 0; i < 12; i = i + 1) begin
            apb(1, 8'h30, (32'hC | i % 4) << (4 * (i / 4)));
            count(3 + i / 4, 16 >> (i % 4));
        end
        apb(1, 8'h30, 32'h4);
        count(3, 8);
        apb(1, 8'h30, 32'h8);
        count(3, 0);
        count(6, 0);
        apb(1, 8'h30, 32'h3000);
        count(6, 8);
        count(7, 8);
        apb(1, 8'h30, 32'hFFFF);
        apb(0, 8'h30, 0);
        check(rd, 32'h7FFF);
        count(3, 2);
        check(padMap, 1);
        deepSleep <= 1;
        debugPortEnable <= 1;
        pause;
        check(padMap, 1);
        deepSleep <= 0;
        pause;
        check(padMap, 0);
        debugPortEnable <= 0;
        pause;
        check(padMap, 1);
        print_verdict;
    end
endmodule // clock_control_bench
